// *** dhm_conv_model.sv ***
`timescale 1ns/1ns
module dhm_conv_model
    import dhm_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // requests from the bench
    input wire logic [DHM_ADC_W-1:0] sample,
    input wire logic convert,
    input wire logic tick,
    // converter side of the block
    output logic [DHM_ADC_W-1:0] adc_result,
    output logic adc_done,
    output logic dac_tick
);
    // result valid only in the done cycle, scrambled otherwise
    always_ff @(posedge clk_sys)
    begin
        adc_done <= convert && !rst;
        adc_result <= rst ? 8'h00 : (convert ? sample : ~adc_result);
        dac_tick <= tick && !rst;
    end
endmodule

// *** dhm_mailbox.sv ***
`timescale 1ns/1ns
module dhm_mailbox
    import dhm_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // host register port
    input wire dhm_host_req_t host_req,
    output logic [7:0] host_rdata,
    // dsp external register port
    input wire dhm_dsp_req_t dsp_req,
    output logic [15:0] dsp_rdata,
    // converters
    input wire logic [DHM_ADC_W-1:0] adc_result,
    input wire logic adc_done,
    input wire logic dac_tick,
    output logic [DHM_DAC_W-1:0] dac_data,
    output logic dac_load,
    output logic [15:0] analog_control_word,
    // interrupts
    output logic host_interrupt_three,
    output logic [2:0] dsp_int_req
);

    // ------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------
    logic [7:0] out_reg [DHM_BYTES];
    logic [7:0] in_reg [DHM_BYTES];
    logic host_interrupt_three_flag_reg;
    logic dsp_top_priority_interrupt_reg;
    logic irq1_reg;
    logic irq0_reg;
    logic [2:0] mask_reg;
    logic gen_en_reg;
    logic [2:0] ipr_reg;
    logic [DHM_ADC_W-1:0] adc_reg;

    // decoded strobes
    logic host_out_wr;
    logic host_ctl_wr;
    logic dsp_mbox_hit;
    logic dsp_icr_wr;
    logic [1:0] dsp_word;

    assign host_out_wr = host_req.bank_sel && host_req.wr && !host_req.addr[3];
    assign host_ctl_wr = host_req.ctl_sel && host_req.wr;
    assign dsp_mbox_hit = dsp_req.addr <= DHM_EXT_MBOX3;
    assign dsp_icr_wr = dsp_req.wr && (dsp_req.addr == DHM_EXT_ICR);
    assign dsp_word = dsp_req.addr[1:0];

    // ------------------------------------------------------------------
    // outgoing bytes: host writes and reads back, dsp only reads
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            for (int i = 0; i < DHM_BYTES; i++)
            begin
                out_reg[i] <= DHM_BYTE_RST;
            end
        end
        else if (host_out_wr)
        begin
            out_reg[host_req.addr[2:0]] <= host_req.wdata;
        end
    end

    // ------------------------------------------------------------------
    // incoming bytes: loaded only by dsp word writes
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            for (int i = 0; i < DHM_BYTES; i++)
            begin
                in_reg[i] <= DHM_BYTE_RST;
            end
        end
        else if (dsp_req.wr && dsp_mbox_hit)
        begin
            in_reg[{dsp_word, 1'b0}] <= dsp_req.wdata[15:8];
            in_reg[{dsp_word, 1'b1}] <= dsp_req.wdata[7:0];
        end
    end

    // ------------------------------------------------------------------
    // host read path, registered
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            host_rdata <= DHM_BYTE_RST;
        end
        else if (host_req.rd && host_req.bank_sel)
        begin
            if (host_req.addr[3])
            begin
                host_rdata <= in_reg[host_req.addr[2:0]];
            end
            else
            begin
                host_rdata <= out_reg[host_req.addr[2:0]];
            end
        end
        else if (host_req.rd && host_req.ctl_sel)
        begin
            host_rdata <= {6'b00_0000, dsp_top_priority_interrupt_reg,
                           host_interrupt_three_flag_reg};
        end
        else
        begin
            host_rdata <= DHM_BYTE_RST;
        end
    end

    // ------------------------------------------------------------------
    // host interrupt three: dsp sets, host clears, set wins
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            host_interrupt_three_flag_reg <= 1'b0;
        end
        else if (dsp_icr_wr && dsp_req.wdata[DHM_ICR_HOST3])
        begin
            host_interrupt_three_flag_reg <= 1'b1;
        end
        else if (host_ctl_wr && host_req.wdata[DHM_CTL_HOST_INTERRUPT_THREE_BIT])
        begin
            host_interrupt_three_flag_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // dsp interrupt flags: host and converter sets win over dsp clear
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            dsp_top_priority_interrupt_reg <= 1'b0;
            irq1_reg <= 1'b0;
            irq0_reg <= 1'b0;
        end
        else
        begin
            if (host_ctl_wr && host_req.wdata[DHM_CTL_TOP_BIT])
            begin
                dsp_top_priority_interrupt_reg <= 1'b1;
            end
            else if (dsp_icr_wr && dsp_req.wdata[DHM_ICR_CLR2])
            begin
                dsp_top_priority_interrupt_reg <= 1'b0;
            end
            if (adc_done)
            begin
                irq1_reg <= 1'b1;
            end
            else if (dsp_icr_wr && dsp_req.wdata[DHM_ICR_CLR1])
            begin
                irq1_reg <= 1'b0;
            end
            if (dac_tick)
            begin
                irq0_reg <= 1'b1;
            end
            else if (dsp_icr_wr && dsp_req.wdata[DHM_ICR_CLR0])
            begin
                irq0_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupt control fields written by the dsp only
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            mask_reg <= 3'b000;
            gen_en_reg <= 1'b0;
            ipr_reg <= DHM_IPR_RST;
        end
        else if (dsp_icr_wr)
        begin
            mask_reg <= dsp_req.wdata[DHM_ICR_MASK2:DHM_ICR_MASK0];
            gen_en_reg <= dsp_req.wdata[DHM_ICR_GEN];
            ipr_reg <= dsp_req.wdata[DHM_ICR_IPR_HI:DHM_ICR_IPR_LO];
        end
    end

    // interrupt lines toward the dsp core and the host
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            dsp_int_req <= 3'b000;
            host_interrupt_three <= 1'b0;
        end
        else
        begin
            dsp_int_req <= {dsp_top_priority_interrupt_reg, irq1_reg, irq0_reg}
                           & mask_reg & {3{gen_en_reg}};
            host_interrupt_three <= host_interrupt_three_flag_reg;
        end
    end

    // ------------------------------------------------------------------
    // converters and analog control
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            dac_data <= '0;
            dac_load <= 1'b0;
            adc_reg <= '0;
            analog_control_word <= DHM_WORD_RST;
        end
        else
        begin
            dac_load <= dsp_req.wr && (dsp_req.addr == DHM_EXT_CONV);
            if (dsp_req.wr && (dsp_req.addr == DHM_EXT_CONV))
            begin
                dac_data <= dsp_req.wdata[DHM_DAC_W-1:0];
            end
            if (adc_done)
            begin
                adc_reg <= adc_result;
            end
            if (dsp_req.wr && (dsp_req.addr == DHM_EXT_ACR))
            begin
                analog_control_word <= dsp_req.wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // dsp read decode, answer on the next edge
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            dsp_rdata <= DHM_WORD_RST;
        end
        else if (dsp_req.rd)
        begin
            case (dsp_req.addr)
                3'h0, 3'h1, 3'h2, 3'h3:
                begin
                    dsp_rdata <= {out_reg[{dsp_word, 1'b0}],
                                  out_reg[{dsp_word, 1'b1}]};
                end
                DHM_EXT_ICR:
                begin
                    dsp_rdata <= {dsp_top_priority_interrupt_reg, irq1_reg, irq0_reg,
                                  mask_reg, 1'b0, gen_en_reg, ipr_reg, 5'b0_0000};
                end
                DHM_EXT_CONV:
                begin
                    dsp_rdata <= {6'b00_0000, adc_reg, 2'b00};
                end
                DHM_EXT_ACR:
                begin
                    dsp_rdata <= analog_control_word;
                end
                default:
                begin
                    dsp_rdata <= DHM_WORD_RST;
                end
            endcase
        end
        else
        begin
            dsp_rdata <= DHM_WORD_RST;
        end
    end

endmodule

// *** dhm_mailbox_props.sv ***
`timescale 1ns/1ns
module dhm_mailbox_props
    import dhm_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // host port
    input wire dhm_host_req_t host_req,
    input wire logic [7:0] host_rdata,
    // dsp port
    input wire dhm_dsp_req_t dsp_req,
    input wire logic [15:0] dsp_rdata,
    // converters
    input wire logic [DHM_ADC_W-1:0] adc_result,
    input wire logic adc_done,
    input wire logic dac_tick,
    input wire logic [DHM_DAC_W-1:0] dac_data,
    input wire logic dac_load,
    input wire logic [15:0] analog_control_word,
    // interrupts
    input wire logic host_interrupt_three,
    input wire logic [2:0] dsp_int_req
);
    // ------------------------------------------------------------------
    // properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // dsp write to one external index
    sequence s_dsp_wr(logic [2:0] a);
        dsp_req.wr && dsp_req.addr == a;
    endsequence

    a_host_idle_zero: assert property (!host_req.rd |=> host_rdata == 8'h00)
        else $error("host read data not zero while idle");
    a_dsp_idle_zero: assert property (!dsp_req.rd |=> dsp_rdata == 16'h0000)
        else $error("dsp read data not zero while idle");
    a_dac_load_data: assert property (s_dsp_wr(DHM_EXT_CONV) |=>
        dac_load && dac_data == $past(dsp_req.wdata[9:0]))
        else $error("dac not loaded by converter write");
    a_dac_load_only: assert property (!dsp_req.wr |=> !dac_load)
        else $error("dac load without a write");
    a_acr_write: assert property (s_dsp_wr(DHM_EXT_ACR) |=>
        analog_control_word == $past(dsp_req.wdata))
        else $error("analog control word not written");
    a_acr_hold: assert property (!dsp_req.wr |=> $stable(analog_control_word))
        else $error("analog control word changed without a write");
    a_host_interrupt_three_raise: assert property (s_dsp_wr(DHM_EXT_ICR) ##0
        dsp_req.wdata[DHM_ICR_HOST3] |-> ##[1:2] host_interrupt_three)
        else $error("host interrupt three not raised");
    a_conv_pad: assert property (dsp_req.rd && dsp_req.addr == DHM_EXT_CONV |=>
        dsp_rdata[1:0] == 2'h0 && dsp_rdata[15:10] == 6'h00)
        else $error("converter read padding not zero");
    a_unmapped_zero: assert property (dsp_req.rd && dsp_req.addr == 3'h7 |=>
        dsp_rdata == 16'h0000)
        else $error("unmapped dsp index read not zero");
endmodule

bind dhm_mailbox dhm_mailbox_props u_props (.clk_sys(clk_sys), .rst(rst),
    .host_req(host_req), .host_rdata(host_rdata), .dsp_req(dsp_req), .dsp_rdata(dsp_rdata),
    .adc_result(adc_result), .adc_done(adc_done), .dac_tick(dac_tick), .dac_data(dac_data),
    .dac_load(dac_load), .analog_control_word(analog_control_word),
    .host_interrupt_three(host_interrupt_three), .dsp_int_req(dsp_int_req));

// *** dhm_mailbox_tb.sv ***
`timescale 1ns/1ns
module dhm_mailbox_tb
    import dhm_pkg::*;
;
    // ------------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic rst, convert, tick, dac_load, host_interrupt_three, adc_done, dac_tick;
    dhm_host_req_t host_req;
    dhm_dsp_req_t dsp_req;
    logic [7:0] host_rdata, sample, adc_result;
    logic [15:0] dsp_rdata, analog_control_word;
    logic [9:0] dac_data;
    logic [2:0] dsp_int_req;
    int miscompares, n_checks;

    // free running clock
    always #5 clk_sys = ~clk_sys;

    dhm_mailbox uut (.clk_sys(clk_sys), .rst(rst), .host_req(host_req),
        .host_rdata(host_rdata), .dsp_req(dsp_req), .dsp_rdata(dsp_rdata),
        .adc_result(adc_result), .adc_done(adc_done), .dac_tick(dac_tick),
        .dac_data(dac_data), .dac_load(dac_load), .analog_control_word(analog_control_word),
        .host_interrupt_three(host_interrupt_three), .dsp_int_req(dsp_int_req));
    dhm_conv_model model (.clk_sys(clk_sys), .rst(rst), .sample(sample), .convert(convert),
        .tick(tick), .adc_result(adc_result), .adc_done(adc_done), .dac_tick(dac_tick));

    // ------------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask

    // one host cycle, read data settled on return
    task automatic host_acc(input logic ctl, input logic [3:0] a, input logic w,
        input logic [7:0] d);
        @(posedge clk_sys);
        #1 host_req = '{bank_sel: !ctl, ctl_sel: ctl, addr: a, rd: !w, wr: w, wdata: d};
        @(posedge clk_sys);
        #1 host_req = '0;
    endtask

    // one dsp cycle, read data settled on return
    task automatic dsp_acc(input logic [2:0] a, input logic w, input logic [15:0] d);
        @(posedge clk_sys);
        #1 dsp_req = '{addr: a, rd: !w, wr: w, wdata: d};
        @(posedge clk_sys);
        #1 dsp_req = '0;
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial
    begin
        rst = 1'b1;
        host_req = '0;
        dsp_req = '0;
        sample = 8'h00;
        convert = 1'b0;
        tick = 1'b0;
        miscompares = 0;
        n_checks = 0;
        repeat (2) @(posedge clk_sys);
        #1 rst = 1'b0;
        for (int i = 0; i < 16; i++)
        begin
            host_acc(1'b0, 4'(i), 1'b0, 8'h00);
            chk("reset byte", 16'h0000, {8'h00, host_rdata});
        end
        for (int i = 0; i < 8; i++)
            host_acc(1'b0, 4'(i), 1'b1, 8'(8'h30 + i));
        for (int i = 0; i < 8; i++)
        begin
            host_acc(1'b0, 4'(i + 8), 1'b1, 8'hff);
            host_acc(1'b0, 4'(i), 1'b0, 8'h00);
            chk("out byte", 16'(8'h30 + i), {8'h00, host_rdata});
            host_acc(1'b0, 4'(i + 8), 1'b0, 8'h00);
            chk("in byte", 16'h0000, {8'h00, host_rdata});
        end
        for (int n = 0; n < 4; n++)
        begin
            dsp_acc(3'(n), 1'b1, 16'(16'ha1b2 + n * 16'h1111));
            dsp_acc(3'(n), 1'b0, 16'h0000);
            chk("dsp word", {8'(8'h30 + 2 * n), 8'(8'h31 + 2 * n)}, dsp_rdata);
            host_acc(1'b0, 4'(8 + 2 * n), 1'b0, 8'h00);
            chk("in high", 16'(8'ha1 + n * 8'h11), {8'h00, host_rdata});
            host_acc(1'b0, 4'(9 + 2 * n), 1'b0, 8'h00);
            chk("in low", 16'(8'hb2 + n * 8'h11), {8'h00, host_rdata});
            host_acc(1'b0, 4'(2 * n), 1'b0, 8'h00);
            chk("out kept", 16'(8'h30 + 2 * n), {8'h00, host_rdata});
        end
        // host interrupt three raised by the dsp, cleared by the host
        dsp_acc(DHM_EXT_ICR, 1'b1, 16'h0200);
        @(posedge clk_sys);
        #1 chk("host_interrupt_three out", 16'h0001, {15'h0000, host_interrupt_three});
        host_acc(1'b1, 4'h0, 1'b1, 8'h00);
        host_acc(1'b1, 4'h0, 1'b0, 8'h00);
        chk("ctl zero write", 16'h0001, {8'h00, host_rdata & 8'h03});
        host_acc(1'b1, 4'h0, 1'b1, 8'h03);
        host_acc(1'b1, 4'h0, 1'b0, 8'h00);
        chk("ctl after", 16'h0002, {8'h00, host_rdata & 8'h03});
        chk("host_interrupt_three cleared", 16'h0000, {15'h0000, host_interrupt_three});
        dsp_acc(DHM_EXT_ICR, 1'b0, 16'h0000);
        chk("icr top", 16'h8000, dsp_rdata & 16'h8000);
        // converter data in both directions
        dsp_acc(DHM_EXT_CONV, 1'b1, 16'h03ff);
        chk("dac data", 16'h03ff, {6'h00, dac_data});
        sample = 8'h5a;
        convert = 1'b1;
        tick = 1'b1;
        @(posedge clk_sys);
        #1 convert = 1'b0;
        tick = 1'b0;
        dsp_acc(DHM_EXT_CONV, 1'b0, 16'h0000);
        chk("adc data", 16'h0168, dsp_rdata);
        dsp_acc(DHM_EXT_ACR, 1'b1, 16'h1234);
        dsp_acc(DHM_EXT_ACR, 1'b0, 16'h0000);
        chk("acr read", 16'h1234, dsp_rdata);
        chk("acr out", 16'h1234, analog_control_word);
        // masks, global enable and priority field, then clear all three flags
        dsp_acc(DHM_EXT_ICR, 1'b1, 16'h1da0);
        dsp_acc(DHM_EXT_ICR, 1'b0, 16'h0000);
        chk("icr all set", 16'hfda0, dsp_rdata);
        chk("int lines on", 16'h0007, {13'h0000, dsp_int_req});
        dsp_acc(DHM_EXT_ICR, 1'b1, 16'h1dbc);
        dsp_acc(DHM_EXT_ICR, 1'b0, 16'h0000);
        chk("icr cleared", 16'h1da0, dsp_rdata);
        chk("int lines off", 16'h0000, {13'h0000, dsp_int_req});
        dsp_acc(3'h7, 1'b0, 16'h0000);
        chk("index 7", 16'h0000, dsp_rdata);
        summarize();
    end
endmodule

// *** dhm_pkg.sv ***
package dhm_pkg;

    // ------------------------------------------------------------------
    // host side byte map (bank b of the expanded register file)
    // ------------------------------------------------------------------
    localparam logic [3:0] DHM_OUT_FIRST = 4'h0;   // mbox_out_w0_high .. w3_low
    localparam logic [3:0] DHM_IN_FIRST = 4'h8;    // mbox_in_w0_high .. w3_low
    localparam int DHM_BYTES = 8;
    localparam int DHM_WORDS = 4;

    // host_dsp_control_register fields
    localparam int DHM_CTL_HOST_INTERRUPT_THREE_BIT = 0;
    localparam int DHM_CTL_TOP_BIT = 1;

    // ------------------------------------------------------------------
    // dsp external register indices
    // ------------------------------------------------------------------
    localparam logic [2:0] DHM_EXT_MBOX0 = 3'h0;
    localparam logic [2:0] DHM_EXT_MBOX3 = 3'h3;
    localparam logic [2:0] DHM_EXT_ICR = 3'h4;
    localparam logic [2:0] DHM_EXT_CONV = 3'h5;
    localparam logic [2:0] DHM_EXT_ACR = 3'h6;

    // dsp_interrupt_control_word fields
    localparam int DHM_ICR_IRQ2 = 15;
    localparam int DHM_ICR_IRQ1 = 14;
    localparam int DHM_ICR_IRQ0 = 13;
    localparam int DHM_ICR_MASK2 = 12;
    localparam int DHM_ICR_MASK0 = 10;
    localparam int DHM_ICR_HOST3 = 9;
    localparam int DHM_ICR_GEN = 8;
    localparam int DHM_ICR_IPR_HI = 7;
    localparam int DHM_ICR_IPR_LO = 5;
    localparam int DHM_ICR_CLR2 = 4;
    localparam int DHM_ICR_CLR1 = 3;
    localparam int DHM_ICR_CLR0 = 2;

    // converter data layout
    localparam int DHM_ADC_LSB = 2;
    localparam int DHM_DAC_W = 10;
    localparam int DHM_ADC_W = 8;

    // reset values
    localparam logic [7:0] DHM_BYTE_RST = 8'h00;
    localparam logic [15:0] DHM_WORD_RST = 16'h0000;
    localparam logic [2:0] DHM_IPR_RST = 3'h0;

    // dsp external register request
    typedef struct packed {
        logic [2:0] addr;
        logic rd;
        logic wr;
        logic [15:0] wdata;
    } dhm_dsp_req_t;

    // host register request
    typedef struct packed {
        logic bank_sel;
        logic ctl_sel;
        logic [3:0] addr;
        logic rd;
        logic wr;
        logic [7:0] wdata;
    } dhm_host_req_t;

endpackage
